// file: pkg/dmd_defines.vh
// Constants shared by the data-memory space decoder and its expanded RAM.
`ifndef DMD_DEFINES_VH
`define DMD_DEFINES_VH

// =====================================================================
// Access kinds presented by the core
`define DMD_KIND_DIRECT      2'h0
`define DMD_KIND_INDIRECT    2'h1
`define DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_BYTE   2'h2
`define DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_WORD   2'h3

// =====================================================================
// Address map
`define DMD_UPPER_BIT        7
`define DMD_IRAM_DEPTH       256
`define DMD_XRAM_DEPTH       768
`define DMD_XRAM_AW          10
`define DMD_XRAM_LAST        16'h02FF
`define DMD_HIGH_PORT_RESET  8'hFF

// =====================================================================
// External bus timing
`define DMD_CLK_PERIOD_NS    10
`define DMD_EXT_ALE_NS       20
`define DMD_EXT_STROBE_NS    60
`define DMD_EXT_ALE_CYC      ((`DMD_EXT_ALE_NS + `DMD_CLK_PERIOD_NS - 1) / `DMD_CLK_PERIOD_NS)
`define DMD_EXT_STROBE_CYC   ((`DMD_EXT_STROBE_NS + `DMD_CLK_PERIOD_NS - 1) / `DMD_CLK_PERIOD_NS)

`endif

// file: rtl/dmd_decoder.v
// Data-memory space decoder: internal RAM, SFR path, expanded RAM and external bus.
`timescale 1ns/100ps
`include "dmd_defines.vh"

// Behaviour
// RULE1 - Bottom 128 internal RAM bytes answer to both direct and indirect access.
// RULE2 - Upper 128 internal RAM bytes answer only to indirect access.
// RULE3 - Special function registers answer only to direct access in the upper range.
// RULE4 - Above 7FH, indirect goes to upper RAM, direct goes to SFRs.
// RULE5 - Upper RAM and SFR storage are separate; writing one never touches the other.
// RULE6 - With expanded RAM enabled, external moves below 300H use on-chip RAM.
// RULE7 - Expanded RAM address comes from either byte pointer or the 16-bit pointer.
// RULE8 - Expanded RAM accesses leave ports and external strobes untouched.
// RULE9 - External moves above the expanded region run a normal multiplexed bus cycle.
// RULE10 - With expanded RAM disabled, every external move goes to the bus.
// RULE11 - Byte pointer bus cycles drive 8 address bits; high port keeps software page.
// RULE12 - Any external move outside the enabled region falls back to a bus cycle.
module dmd_decoder
(
  input  wire        mclk,                // Core clock.
  input  wire        reset,               // Synchronous reset, active high.
  input  wire        reqValid,            // Core presents an access.
  input  wire [1:0]  reqKind,             // Direct, indirect, byte-pointer move or word-pointer move.
  input  wire [15:0] reqAddr,             // Access address.
  input  wire        reqWrite,            // High for a write.
  input  wire [7:0]  reqWdata,            // Write data.
  output wire        reqReady,            // Access is taken while high.
  output wire        rspValid,            // One-cycle pulse with the access result.
  output wire [7:0]  rspData,             // Read data, valid with rspValid.
  input  wire        expandedRamDisable,  // Auxiliary control bit, high sends moves off-chip.
  input  wire [7:0]  highPortLatch,       // Software value of the high address port.
  output wire        sfrStrobe,           // One-cycle SFR access pulse.
  output wire        sfrWrite,            // SFR access is a write.
  output wire [7:0]  sfrAddr,             // SFR address.
  output wire [7:0]  sfrWdata,            // SFR write data.
  input  wire [7:0]  sfrRdata,            // SFR read data, sampled during sfrStrobe.
  output wire [7:0]  lowPortOut,          // Low address/data port drive value.
  output wire        lowPortOe,           // Low port driven while high.
  input  wire [7:0]  lowPortIn,           // Low port pin level.
  output wire [7:0]  highPortOut,         // High address port.
  output wire        addrLatchEnable,     // Address latch strobe, active high.
  output wire        extWriteStrobeN,     // External write strobe, active low.
  output wire        extReadStrobeN       // External read strobe, active low.
);

  // =====================================================================
  // States
  // IDLE takes a request; internal and expanded RAM answer from there in one cycle.
  // SFR holds the strobe for one cycle while the register outside answers.
  // ALE and STB make the external cycle; HOLD keeps write data driven past the strobe.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SFR  = 5'h02;
  localparam [4:0] ST_ALE  = 5'h04;
  localparam [4:0] ST_STB  = 5'h08;
  localparam [4:0] ST_HOLD = 5'h10;

  // Phase lengths round up, so a pin never stands shorter than the bus needs.
  // The counter is four bits wide, which bounds each phase to sixteen cycles.
  localparam integer ALE_CYC_N = `DMD_EXT_ALE_CYC;
  localparam integer STB_CYC_N = `DMD_EXT_STROBE_CYC;
  localparam [3:0]   ALE_CYC   = ALE_CYC_N[3:0];
  localparam [3:0]   STB_CYC   = STB_CYC_N[3:0];

  reg [4:0]  state_q;
  reg [3:0]  cnt_q;
  reg        ready_q;
  reg        rspValid_q;
  reg [7:0]  rspData_q;
  reg        sfrStrobe_q;
  reg        sfrWrite_q;
  reg [7:0]  sfrAddr_q;
  reg [7:0]  sfrWdata_q;
  reg [7:0]  lowOut_q;
  reg        lowOe_q;
  reg [7:0]  highOut_q;
  reg        ale_q;
  reg        wrN_q;
  reg        rdN_q;
  reg        extWrite_q;
  reg [7:0]  extWdata_q;

  reg [7:0]  iram [0:`DMD_IRAM_DEPTH-1];

  wire        accept;
  wire        isMovx;
  wire        isByteMovx;
  wire [15:0] movxAddr;
  wire        hitXram;
  wire        hitSfr;
  wire        hitIram;
  wire        goExt;
  wire [7:0]  xramRd;

  // =====================================================================
  // Decode
  assign accept     = reqValid & ready_q;
  assign isMovx     = reqKind[1];
  assign isByteMovx = (reqKind == `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_BYTE);
  // A byte pointer reaches only the first 256 bytes of the region.
  assign movxAddr   = isByteMovx ? {8'h00, reqAddr[7:0]} : reqAddr;                  // RULE7
  assign hitXram    = isMovx & ~expandedRamDisable & (movxAddr <= `DMD_XRAM_LAST);   // RULE6
  assign goExt      = isMovx & ~hitXram;                                              // RULE10 RULE12
  assign hitSfr     = (reqKind == `DMD_KIND_DIRECT) & reqAddr[`DMD_UPPER_BIT];        // RULE3 RULE4
  assign hitIram    = ~isMovx & ~hitSfr;                                              // RULE1 RULE2 RULE4

  // =====================================================================
  // Storage
  // SFRs live outside this block, so the upper RAM array cannot alias them.
  always @(posedge mclk)
  begin
    if (accept && hitIram && reqWrite)
    begin
      iram[reqAddr[7:0]] <= reqWdata;                                                 // RULE5
    end
  end

  dmd_xram u_xram
  (
    .mclk   (mclk),
    .wrEn   (accept & hitXram & reqWrite),
    .index  (movxAddr[`DMD_XRAM_AW-1:0]),
    .wrData (reqWdata),
    .rdData (xramRd)
  );

  // =====================================================================
  // Sequencer
  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'h0;
      ready_q     <= 1'b0;
      rspValid_q  <= 1'b0;
      rspData_q   <= 8'h00;
      sfrStrobe_q <= 1'b0;
      sfrWrite_q  <= 1'b0;
      sfrAddr_q   <= 8'h00;
      sfrWdata_q  <= 8'h00;
      lowOut_q    <= 8'h00;
      lowOe_q     <= 1'b0;
      highOut_q   <= `DMD_HIGH_PORT_RESET;
      ale_q       <= 1'b0;
      wrN_q       <= 1'b1;
      rdN_q       <= 1'b1;
      extWrite_q  <= 1'b0;
      extWdata_q  <= 8'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          ready_q     <= 1'b1;
          rspValid_q  <= 1'b0;
          highOut_q   <= highPortLatch;
          if (accept)
          begin
            if (hitSfr)
            begin
              ready_q     <= 1'b0;
              sfrStrobe_q <= 1'b1;
              sfrWrite_q  <= reqWrite;
              sfrAddr_q   <= reqAddr[7:0];
              sfrWdata_q  <= reqWdata;
              state_q     <= ST_SFR;                                                  // RULE3
            end
            else if (hitIram)
            begin
              rspData_q  <= iram[reqAddr[7:0]];                                       // RULE1 RULE2
              rspValid_q <= 1'b1;
            end
            else if (hitXram)
            begin
              // Pins are not touched at all on this path.
              rspData_q  <= xramRd;                                                   // RULE8
              rspValid_q <= 1'b1;
            end
            else
            begin
              ready_q    <= 1'b0;
              extWrite_q <= reqWrite;
              extWdata_q <= reqWdata;
              ale_q      <= 1'b1;
              lowOut_q   <= movxAddr[7:0];                                            // RULE9
              lowOe_q    <= 1'b1;
              // The byte pointer leaves the high port at the software page value.
              highOut_q  <= isByteMovx ? highPortLatch : movxAddr[15:8];              // RULE11
              cnt_q      <= ALE_CYC - 4'h1;
              state_q    <= ST_ALE;
            end
          end
        end
        ST_SFR:
        begin
          sfrStrobe_q <= 1'b0;
          rspData_q   <= sfrWrite_q ? 8'h00 : sfrRdata;
          rspValid_q  <= 1'b1;
          ready_q     <= 1'b1;
          state_q     <= ST_IDLE;
        end
        ST_ALE:
        begin
          if (cnt_q == 4'h0)
          begin
            ale_q <= 1'b0;
            cnt_q <= STB_CYC - 4'h1;
            if (extWrite_q)
            begin
              lowOut_q <= extWdata_q;
              wrN_q    <= 1'b0;                                                       // RULE9
            end
            else
            begin
              lowOe_q <= 1'b0;
              rdN_q   <= 1'b0;                                                        // RULE9
            end
            state_q <= ST_STB;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_STB:
        begin
          if (cnt_q == 4'h0)
          begin
            wrN_q      <= 1'b1;
            rdN_q      <= 1'b1;
            rspData_q  <= extWrite_q ? 8'h00 : lowPortIn;
            rspValid_q <= 1'b1;
            state_q    <= ST_HOLD;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_HOLD:
        begin
          // Write data is held one cycle past the strobe for external hold time.
          lowOe_q    <= 1'b0;
          rspValid_q <= 1'b0;
          ready_q    <= 1'b1;
          highOut_q  <= highPortLatch;
          state_q    <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // Outputs
  assign reqReady        = ready_q;
  assign rspValid        = rspValid_q;
  assign rspData         = rspData_q;
  assign sfrStrobe       = sfrStrobe_q;
  assign sfrWrite        = sfrWrite_q;
  assign sfrAddr         = sfrAddr_q;
  assign sfrWdata        = sfrWdata_q;
  assign lowPortOut      = lowOut_q;
  assign lowPortOe       = lowOe_q;
  assign highPortOut     = highOut_q;
  assign addrLatchEnable = ale_q;
  assign extWriteStrobeN = wrN_q;
  assign extReadStrobeN  = rdN_q;

endmodule

// file: rtl/dmd_xram.v
// On-chip expanded RAM storage with synchronous write and direct read.
`timescale 1ns/100ps
`include "dmd_defines.vh"

module dmd_xram
(
  input  wire                     mclk,    // Core clock.
  input  wire                     wrEn,    // Write this cycle.
  input  wire [`DMD_XRAM_AW-1:0]  index,   // Byte index, below the depth.
  input  wire [7:0]               wrData,  // Byte to store.
  output wire [7:0]               rdData   // Byte at index.
);

  reg [7:0] mem [0:`DMD_XRAM_DEPTH-1];

  // =====================================================================
  // Storage
  always @(posedge mclk)
  begin
    if (wrEn)
    begin
      mem[index] <= wrData;
    end
  end

  assign rdData = mem[index];

endmodule

// file: test/dmd_decoder_assertions.sv
// Port checks for the data-memory space decoder.
`timescale 1ns/100ps
`include "dmd_defines.vh"
module dmd_decoder_checker
(
  input wire        mclk,               // Clock.
  input wire        reset,              // Reset.
  input wire        reqValid,           // Offer.
  input wire [1:0]  reqKind,            // Kind.
  input wire [15:0] reqAddr,            // Address.
  input wire        reqWrite,           // Write.
  input wire        reqReady,           // Ready.
  input wire        rspValid,           // Answer.
  input wire        expandedRamDisable, // Disable.
  input wire [7:0]  highPortLatch,      // Page.
  input wire        sfrStrobe,          // SFR pulse.
  input wire [7:0]  lowPortOut,         // Low port.
  input wire        lowPortOe,          // Low drive.
  input wire [7:0]  highPortOut,        // High port.
  input wire        addrLatchEnable,    // ALE.
  input wire        extWriteStrobeN,    // Write strobe.
  input wire        extReadStrobeN      // Read strobe.
);
  // ====================================================================
  // Decode helpers
  wire take = reqValid && reqReady;
  wire dir  = reqKind == `DMD_KIND_DIRECT;
  wire inX  = !expandedRamDisable && (reqKind == `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_BYTE || reqAddr <= `DMD_XRAM_LAST);
  wire bus  = take && reqKind[1] && !inX;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_addr;
    addrLatchEnable [*2];
  endsequence
  sequence s_rd;
    (!addrLatchEnable && !extReadStrobeN) [*6] ##1 (extReadStrobeN && rspValid);
  endsequence
  sequence s_wr;
    (!extWriteStrobeN && lowPortOe) [*6] ##1 (extWriteStrobeN && rspValid);
  endsequence
  // ====================================================================
  // Assertions
  a_low_iram: assert property (take && dir && !reqAddr[7] |=> rspValid && !sfrStrobe)
    else $error("low direct access not served from RAM");
  a_upper_indirect: assert property (take && reqKind == `DMD_KIND_INDIRECT |=> rspValid && !sfrStrobe)
    else $error("indirect access reached the SFR path");
  a_sfr_direct: assert property (take && dir && reqAddr[7] |=> sfrStrobe && !rspValid ##1 rspValid)
    else $error("upper direct access missed the SFR path");
  a_xram_quiet: assert property (take && reqKind[1] && inX |=> rspValid && !addrLatchEnable && !lowPortOe
    && extReadStrobeN && extWriteStrobeN)
    else $error("expanded RAM access moved bus pins");
  a_bus_read: assert property (bus && !reqWrite |=> s_addr ##1 s_rd)
    else $error("external read cycle malformed");
  a_bus_write: assert property (bus && reqWrite |=> s_addr ##1 s_wr)
    else $error("external write cycle malformed");
  a_byte_addr: assert property (bus && reqKind == `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_BYTE |=>
    lowPortOut == $past(reqAddr[7:0]) && highPortOut == $past(highPortLatch))
    else $error("byte pointer address wrong");
  a_word_addr: assert property (bus && reqKind == `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_WORD |=>
    {highPortOut, lowPortOut} == $past(reqAddr))
    else $error("word pointer address wrong");
endmodule

bind dmd_decoder dmd_decoder_checker chk (.mclk(mclk), .reset(reset), .reqValid(reqValid),
  .reqKind(reqKind), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqReady(reqReady), .rspValid(rspValid),
  .expandedRamDisable(expandedRamDisable), .highPortLatch(highPortLatch), .sfrStrobe(sfrStrobe),
  .lowPortOut(lowPortOut), .lowPortOe(lowPortOe), .highPortOut(highPortOut),
  .addrLatchEnable(addrLatchEnable), .extWriteStrobeN(extWriteStrobeN), .extReadStrobeN(extReadStrobeN));

// file: test/dmd_decoder_tb.sv
// Random accesses checked against a model keyed by memory space.
`timescale 1ns/100ps
`include "dmd_defines.vh"
module dmd_decoder_tb;
  logic        mclk = 1'b0, reset = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, expandedRamDisable = 1'b0;
  logic [1:0]  reqKind = 2'h0;
  logic [15:0] reqAddr = 16'h0000;
  logic [7:0]  reqWdata = 8'h00, highPortLatch = 8'h00;
  wire         reqReady, rspValid, sfrStrobe, sfrWrite, lowPortOe, addrLatchEnable, extWriteStrobeN, extReadStrobeN;
  wire  [7:0]  rspData, sfrAddr, sfrWdata, sfrRdata, lowPortOut, lowPortIn, highPortOut;
  int          miscompares = 0, check_count = 0, cycles = 0, key;
  logic [7:0]  model [int];
  logic [15:0] a;
  logic [1:0]  k;
  logic        w;
  dmd_decoder uut (.mclk(mclk), .reset(reset), .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr),
    .reqWrite(reqWrite), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .expandedRamDisable(expandedRamDisable), .highPortLatch(highPortLatch), .sfrStrobe(sfrStrobe),
    .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .lowPortOut(lowPortOut),
    .lowPortOe(lowPortOe), .lowPortIn(lowPortIn), .highPortOut(highPortOut), .addrLatchEnable(addrLatchEnable),
    .extWriteStrobeN(extWriteStrobeN), .extReadStrobeN(extReadStrobeN));
  dmd_far_side far (.mclk(mclk), .lowPortOut(lowPortOut), .lowPortOe(lowPortOe), .highPortOut(highPortOut),
    .addrLatchEnable(addrLatchEnable), .extWriteStrobeN(extWriteStrobeN), .extReadStrobeN(extReadStrobeN),
    .sfrStrobe(sfrStrobe), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .lowPortIn(lowPortIn),
    .sfrRdata(sfrRdata));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // ====================================================================
  // Shared tasks
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Called at a falling edge; one idle cycle keeps reqValid from being set twice in a step.
  task automatic access;
    int n;
    n = 0;
    @(negedge mclk);
    {reqKind, reqAddr, reqWrite, reqValid} = {k, a, w, 1'b1};
    reqWdata = $urandom;
    while (reqReady !== 1'b1 && n < 30)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 30)
    begin
      @(negedge mclk);
      n++;
    end
    check("response", {7'h00, rspValid}, 8'h01);
    if (w)
      model[key] = reqWdata;
    else
      check("read data", rspData, model[key]);
  endtask
  // ====================================================================
  // Main sequence
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict;
    end
  end
  initial
  begin
    void'($urandom(60));
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    repeat (400)
    begin
      k = $urandom;
      a = $urandom;
      // Most addresses sit near the expanded region so its edge at 2FFH is crossed often.
      if ($urandom % 4 != 0) a = a % 16'h0340;
      if (k != `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_WORD) a[15:8] = 8'h00;
      if ($urandom % 16 == 0) expandedRamDisable = ~expandedRamDisable;
      highPortLatch = $urandom % 4;
      if (k == `DMD_KIND_INDIRECT || (k == `DMD_KIND_DIRECT && !a[7])) key = a[7:0];
      else if (k == `DMD_KIND_DIRECT) key = 256 + a[7:0];
      else if (!expandedRamDisable && (k == `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_BYTE || a <= 16'h02FF)) key = 512 + a;
      else key = 2048 + ((k == `DMD_KIND_EXTERNAL_MOVE_INSTRUCTION_BYTE) ? {highPortLatch, a[7:0]} : a);
      w = !model.exists(key) || ($urandom % 2);
      access;
    end
    print_verdict;
  end
endmodule

// file: test/dmd_far_side.sv
// External data memory and SFR storage facing the decoder.
`timescale 1ns/100ps
module dmd_far_side
(
  input  wire       mclk,            // Clock.
  input  wire [7:0] lowPortOut,      // Low port.
  input  wire       lowPortOe,       // Low drive.
  input  wire [7:0] highPortOut,     // High port.
  input  wire       addrLatchEnable, // ALE.
  input  wire       extWriteStrobeN, // Write strobe.
  input  wire       extReadStrobeN,  // Read strobe.
  input  wire       sfrStrobe,       // SFR pulse.
  input  wire       sfrWrite,        // SFR write.
  input  wire [7:0] sfrAddr,         // SFR address.
  input  wire [7:0] sfrWdata,        // SFR data.
  output wire [7:0] lowPortIn,       // Pin level.
  output wire [7:0] sfrRdata         // SFR read.
);
  logic [7:0]  extMem [0:65535];
  logic [7:0]  sfrMem [0:255];
  logic [15:0] busAddr;
  logic [7:0]  junk = 8'h5A;
  always @(posedge mclk)
  begin
    junk <= ~junk;
    if (addrLatchEnable) busAddr <= {highPortOut, lowPortOut};
    if (!extWriteStrobeN) extMem[busAddr] <= lowPortOut;
    if (sfrStrobe && sfrWrite) sfrMem[sfrAddr] <= sfrWdata;
  end
  // A released line toggles every cycle, so stale data can never pass for an answer.
  assign lowPortIn = !extReadStrobeN ? extMem[busAddr] : (lowPortOe ? lowPortOut : junk);
  assign sfrRdata  = sfrStrobe ? sfrMem[sfrAddr] : junk;
endmodule
